/* iq_corr_pkg.sv */
// iq_corr_pkg: register map, field layout, reset values and carrier types
// for the quadrature correction block.
// assumes a 32-bit wishbone data bus with word-aligned registers.
package iq_corr_pkg;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_DC_I    = 8'h04;
    localparam logic [7:0] OFS_DC_Q    = 8'h08;
    localparam logic [7:0] OFS_GAIN    = 8'h0c;
    localparam logic [7:0] OFS_SKEW    = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;

    localparam int BIT_DC_EN    = 0;
    localparam int BIT_SKEW_EN  = 1;
    localparam int BIT_GAIN_EN  = 2;
    localparam int POS_DC_RATE  = 4;
    localparam int POS_SKW_RATE = 8;
    localparam int POS_GN_RATE  = 12;

    localparam logic [15:0] RST_CONTROL = 16'h0000;
    localparam logic [15:0] RST_DC      = 16'h0000;
    localparam logic [15:0] RST_SKEW    = 16'h0000;
    // unity gain correction term: zero means Q unchanged
    localparam logic [15:0] RST_GAIN    = 16'h0000;

    localparam int RATE_BASE_LOG2 = 12;
    localparam logic [3:0] RATE_MAX = 4'hb;
    // correction terms: 14-bit signed, full scale 2^16 = 1.0, so +-0.125 is +-2^13
    localparam int TERM_FRAC = 16;
    localparam logic signed [15:0] TERM_LIMIT = 16'sh1fff;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } iq_sample_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;
endpackage : iq_corr_pkg

/* iq_fifo.sv */
// iq_fifo: synchronous fifo with valid/ready on both sides.
// assumes one clock; full and empty are exact.
`timescale 1ns/1ns
module iq_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             srst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      rdPtr_q;
    wire              isFull  = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    wire              isEmpty = (wrPtr_q == rdPtr_q);
    wire              doPush  = inValid && !isFull;
    wire              doPop   = outReady && !isEmpty;

    assign inReady  = !isFull;
    assign outValid = !isEmpty;
    assign outData  = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (doPush) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + (AW+1)'(doPush);
            rdPtr_q <= rdPtr_q + (AW+1)'(doPop);
        end
    end
endmodule : iq_fifo

/* iq_quadrature_correction.sv */
// iq_quadrature_correction: dc, skew and gain correction of one complex pair.
// Behaviour
// - two instances are built, one for the A/B pair and one for the C/D pair.
// - the instance only corrects when complex mode is on, otherwise samples pass unchanged.
// - three separate control bits enable the dc, skew and gain loops independently.
// - separate I and Q dc estimators each subtract their estimate from their own path.
// - the dc estimate is a first-order decimating cic followed by a second-order interpolating cic, same factor.
// - a 4-bit dc rate field gives factor 2^(12+field), 0 to 11.
// - the dc estimates read as 16-bit msb-aligned values subtracted from msb-aligned samples.
// - with dc loop off the register offsets are still subtracted.
// - the skew error is integrated by a first-order decimating cic with factor from bits 11:8.
// - while skew loop runs Q times the estimate is added to I and a read of the skew register returns the estimate.
// - while skew loop runs the skew term spans +-0.125 at 14-bit resolution.
// - with skew loop off Q times the register value is added to I.
// - the gain loop estimates |I|-|Q| with a first-order decimating cic of 2^12 to 2^23.
// - while gain loop runs Q times the estimate is added to Q, range 0.875 to 1.125.
// - with gain loop off the register value is applied to Q.
// assumes samples arrive synchronous to ref_clk, one per sampleValid.
`timescale 1ns/1ns
module iq_corr_core (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    srst,
    // control
    input  wire logic                    complexMode,
    input  wire logic [15:0]             control,
    input  wire logic [15:0]             dcIReg,
    input  wire logic [15:0]             dcQReg,
    input  wire logic [15:0]             gainReg,
    input  wire logic [15:0]             skewReg,
    // estimates
    output logic      [15:0]             dcIEst,
    output logic      [15:0]             dcQEst,
    output logic      [15:0]             gainEst,
    output logic      [15:0]             skewEst,
    // stream
    input  wire logic                    sampleValid,
    input  wire iq_corr_pkg::iq_sample_t sampleIn,
    output logic                         outValid,
    output iq_corr_pkg::iq_sample_t      sampleOut
);
    import iq_corr_pkg::*;

    wire dcOn   = control[BIT_DC_EN] && complexMode;
    wire skewOn = control[BIT_SKEW_EN] && complexMode;
    wire gainOn = control[BIT_GAIN_EN] && complexMode;
    wire [3:0] dcRate = control[POS_DC_RATE +: 4];
    wire [3:0] skRate = control[POS_SKW_RATE +: 4];
    wire [3:0] gnRate = control[POS_GN_RATE +: 4];

    function automatic logic [4:0] shiftOf(input logic [3:0] r);
        shiftOf = 5'(RATE_BASE_LOG2) + {1'b0, (r > RATE_MAX) ? RATE_MAX : r};
    endfunction : shiftOf

    // per-loop decimation counters: dump strobe every 2^(12+rate) samples
    logic [23:0] dcCnt_q, skCnt_q, gnCnt_q;
    wire  [23:0] dcMask = 24'hffffff >> (5'd24 - shiftOf(dcRate));
    wire  [23:0] skMask = 24'hffffff >> (5'd24 - shiftOf(skRate));
    wire  [23:0] gnMask = 24'hffffff >> (5'd24 - shiftOf(gnRate));
    wire  dcDump = sampleValid && ((dcCnt_q & dcMask) == dcMask);
    wire  skDump = sampleValid && ((skCnt_q & skMask) == skMask);
    wire  gnDump = sampleValid && ((gnCnt_q & gnMask) == gnMask);

    // applied terms: estimate while a loop runs, register otherwise
    wire signed [15:0] dcI  = dcOn   ? dcIEst  : dcIReg;
    wire signed [15:0] dcQ  = dcOn   ? dcQEst  : dcQReg;
    wire signed [15:0] skT  = skewOn ? skewEst : skewReg;
    wire signed [15:0] gnT  = gainOn ? gainEst : gainReg;

    wire signed [16:0] iDc  = 17'(sampleIn.i) - 17'(dcI);
    wire signed [16:0] qDc  = 17'(sampleIn.q) - 17'(dcQ);
    wire signed [33:0] skP  = 34'(qDc) * 34'(skT);
    wire signed [33:0] gnP  = 34'(qDc) * 34'(gnT);
    wire signed [17:0] iCor = 18'(iDc) + 18'(skP >>> TERM_FRAC);
    wire signed [17:0] qCor = 18'(qDc) + 18'(gnP >>> TERM_FRAC);

    function automatic logic [15:0] sat16(input logic signed [17:0] v);
        if (v > 18'sd32767) sat16 = 16'h7fff;
        else if (v < -18'sd32768) sat16 = 16'h8000;
        else sat16 = v[15:0];
    endfunction : sat16

    function automatic logic [15:0] clampTerm(input logic signed [31:0] v);
        if (v > 32'(TERM_LIMIT)) clampTerm = TERM_LIMIT;
        else if (v < -32'(TERM_LIMIT)) clampTerm = -TERM_LIMIT;
        else clampTerm = v[15:0];
    endfunction : clampTerm

    // error terms fed to the integrators
    wire signed [31:0] skErr = 32'(signed'(sat16(iCor))) * 32'(signed'(sat16(qCor))); // I*Q ~ sin(skew)
    wire [15:0]        absI  = iCor[17] ? 16'(-iCor) : 16'(iCor);
    wire [15:0]        absQ  = qCor[17] ? 16'(-qCor) : 16'(qCor);
    wire signed [17:0] gnErr = 18'(absI) - 18'(absQ);   // drives |Q| toward |I|

    // dc loop: first-order decimating cic then second-order interpolating cic
    logic signed [47:0] dcAccI_q, dcAccQ_q;      // decimator integrators
    logic signed [15:0] dcStepI_q, dcStepQ_q;    // per-sample slope of interpolator
    logic signed [47:0] skAcc_q, gnAcc_q;
    logic signed [31:0] skTerm_q, gnTerm_q;
    logic signed [31:0] dcEstI_q, dcEstQ_q;      // 16.16 running estimates
    wire  [4:0]  dcSh = shiftOf(dcRate);
    wire  signed [47:0] dcMeanI = (dcAccI_q + 48'(iDc)) >>> dcSh;
    wire  signed [47:0] dcMeanQ = (dcAccQ_q + 48'(qDc)) >>> dcSh;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dcCnt_q <= '0;
            skCnt_q <= '0;
            gnCnt_q <= '0;
        end else if (sampleValid) begin
            dcCnt_q <= dcCnt_q + 24'h1;
            skCnt_q <= skCnt_q + 24'h1;
            gnCnt_q <= gnCnt_q + 24'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || !dcOn) begin
            dcAccI_q  <= '0;
            dcAccQ_q  <= '0;
            dcStepI_q <= '0;
            dcStepQ_q <= '0;
            dcEstI_q  <= {dcIReg, 16'h0000};
            dcEstQ_q  <= {dcQReg, 16'h0000};
        end else if (sampleValid) begin
            dcAccI_q <= dcDump ? '0 : dcAccI_q + 48'(iDc);
            dcAccQ_q <= dcDump ? '0 : dcAccQ_q + 48'(qDc);
            if (dcDump) begin
                // residual mean sets the interpolator slope for the next block
                dcStepI_q <= 16'(dcMeanI);
                dcStepQ_q <= 16'(dcMeanQ);
            end
            // one block moves the estimate by 1/16 of the residual at rate 0; higher rates truncate the per-sample step:
            // slow to settle, and small negative steps can overshoot; shifts keep negative steps signed
            dcEstI_q <= dcEstI_q + ((32'(dcStepI_q) <<< (5'd28 - dcSh)) >>> 16);
            dcEstQ_q <= dcEstQ_q + ((32'(dcStepQ_q) <<< (5'd28 - dcSh)) >>> 16);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || !skewOn) begin
            skAcc_q  <= '0;
            skTerm_q <= 32'(signed'(skewReg));
        end else if (sampleValid) begin
            skAcc_q <= skDump ? '0 : skAcc_q + 48'(skErr);
            if (skDump) begin
                skTerm_q <= 32'(signed'(clampTerm(skTerm_q - 32'((skAcc_q >>> shiftOf(skRate)) >>> 16))));
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || !gainOn) begin
            gnAcc_q  <= '0;
            gnTerm_q <= 32'(signed'(gainReg));
        end else if (sampleValid) begin
            gnAcc_q <= gnDump ? '0 : gnAcc_q + 48'(gnErr);
            if (gnDump) begin
                gnTerm_q <= 32'(signed'(clampTerm(gnTerm_q + 32'(gnAcc_q >>> shiftOf(gnRate)))));
            end
        end
    end

    // reads show the register itself while a loop is off, unclamped and without lag
    assign dcIEst  = dcOn ? dcEstI_q[31:16] : dcIReg;
    assign dcQEst  = dcOn ? dcEstQ_q[31:16] : dcQReg;
    assign skewEst = skewOn ? clampTerm(skTerm_q) : skewReg;
    assign gainEst = gainOn ? clampTerm(gnTerm_q) : gainReg;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            outValid  <= 1'b0;
            sampleOut <= '0;
        end else begin
            outValid <= sampleValid;
            if (sampleValid) begin
                sampleOut <= complexMode ? '{i: sat16(iCor), q: sat16(qCor)} : sampleIn;
            end
        end
    end
endmodule : iq_corr_core

module iq_quadrature_correction (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    srst,
    // wishbone classic slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         wb_err_o,
    // input ports, complex mode per pair
    input  wire logic                    complexAB,
    input  wire logic                    complexCD,
    input  wire logic                    sampleValid,
    output logic                         sampleReady,
    input  wire iq_corr_pkg::iq_sample_t sampleAB,
    input  wire iq_corr_pkg::iq_sample_t sampleCD,
    // corrected output stream, both pairs per word
    output logic                         outValid,
    input  wire logic                    outReady,
    output iq_corr_pkg::iq_sample_t      outAB,
    output iq_corr_pkg::iq_sample_t      outCD
);
    import iq_corr_pkg::*;

    // register banks for both instances: [0] = AB, [1] = CD; bank index is adr bit 7
    logic [15:0] ctrl_q [2];
    logic [15:0] dcI_q  [2];
    logic [15:0] dcQ_q  [2];
    logic [15:0] gain_q [2];
    logic [15:0] skew_q [2];
    logic [15:0] eDcI [2], eDcQ [2], eGain [2], eSkew [2];
    logic        cVal [2];
    iq_sample_t  cOut [2];
    logic        ack_q;

    wire        req     = wb_cyc_i && wb_stb_i && !ack_q;
    wire        bank    = wb_adr_i[7];
    wire [7:0]  regOfs  = {1'b0, wb_adr_i[6:0]};
    wire        hitCtl  = regOfs == OFS_CONTROL;
    wire        hitDcI  = regOfs == OFS_DC_I;
    wire        hitDcQ  = regOfs == OFS_DC_Q;
    wire        hitGain = regOfs == OFS_GAIN;
    wire        hitSkew = regOfs == OFS_SKEW;
    wire        hitStat = regOfs == OFS_STATUS;
    wire        mapped  = hitCtl | hitDcI | hitDcQ | hitGain | hitSkew | hitStat;
    wire        wrLo    = req && wb_we_i && mapped && wb_sel_i[0];
    wire        wrHi    = req && wb_we_i && mapped && wb_sel_i[1];
    wire [15:0] cmplx   = {15'h0, bank ? complexCD : complexAB};

    // reads return the live estimates while a loop runs, else the stored value
    wire [15:0] rdVal = hitCtl  ? ctrl_q[bank] :
                        hitDcI  ? eDcI[bank]   :
                        hitDcQ  ? eDcQ[bank]   :
                        hitGain ? eGain[bank]  :
                        hitSkew ? eSkew[bank]  :
                        hitStat ? cmplx        : 16'h0000;

    // stream enters through the fifo; core runs only when a word is accepted
    logic        fVal;
    logic [63:0] fData;
    wire         coreGo  = fVal && outReady;

    iq_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .inData   ({sampleAB, sampleCD}),
        .outValid (fVal),
        .outReady (outReady),
        .outData  (fData)
    );

    for (genvar k = 0; k < 2; k++) begin : g_inst
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                ctrl_q[k] <= RST_CONTROL;
                dcI_q[k]  <= RST_DC;
                dcQ_q[k]  <= RST_DC;
                gain_q[k] <= RST_GAIN;
                skew_q[k] <= RST_SKEW;
            end else if (bank == 1'(k)) begin
                if (hitCtl)  ctrl_q[k] <= {wrHi ? wb_dat_i[15:8] : ctrl_q[k][15:8], wrLo ? wb_dat_i[7:0] : ctrl_q[k][7:0]};
                if (hitDcI)  dcI_q[k]  <= {wrHi ? wb_dat_i[15:8] : dcI_q[k][15:8],  wrLo ? wb_dat_i[7:0] : dcI_q[k][7:0]};
                if (hitDcQ)  dcQ_q[k]  <= {wrHi ? wb_dat_i[15:8] : dcQ_q[k][15:8],  wrLo ? wb_dat_i[7:0] : dcQ_q[k][7:0]};
                if (hitGain) gain_q[k] <= {wrHi ? wb_dat_i[15:8] : gain_q[k][15:8], wrLo ? wb_dat_i[7:0] : gain_q[k][7:0]};
                if (hitSkew) skew_q[k] <= {wrHi ? wb_dat_i[15:8] : skew_q[k][15:8], wrLo ? wb_dat_i[7:0] : skew_q[k][7:0]};
            end
        end

        iq_corr_core u_core (
            .ref_clk     (ref_clk),
            .srst        (srst),
            .complexMode (k == 0 ? complexAB : complexCD),
            .control     (ctrl_q[k]),
            .dcIReg      (dcI_q[k]),
            .dcQReg      (dcQ_q[k]),
            .gainReg     (gain_q[k]),
            .skewReg     (skew_q[k]),
            .dcIEst      (eDcI[k]),
            .dcQEst      (eDcQ[k]),
            .gainEst     (eGain[k]),
            .skewEst     (eSkew[k]),
            .sampleValid (coreGo),
            .sampleIn    (k == 0 ? fData[63:32] : fData[31:0]),
            .outValid    (cVal[k]),
            .sampleOut   (cOut[k])
        );
    end

    assign outValid = cVal[0];
    assign outAB    = cOut[0];
    assign outCD    = cOut[1];
    assign wb_err_o = 1'b0;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_q    <= req;
            wb_dat_o <= req ? {16'h0000, rdVal} : 32'h0;
        end
    end
    assign wb_ack_o = ack_q;

    // bus, stream and correction term checks
    a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (srst)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    a_ack_follows_req: assert property (@(posedge ref_clk) disable iff (srst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
    a_bypass_real: assert property (@(posedge ref_clk) disable iff (srst)
        (coreGo && !complexAB) |=> (outAB == $past(fData[63:32]))) else $error("real data not bypassed");
    a_bypass_cd: assert property (@(posedge ref_clk) disable iff (srst)
        (coreGo && !complexCD) |=> (outCD == $past(fData[31:0]))) else $error("real data not bypassed on cd");
    a_pair_lockstep: assert property (@(posedge ref_clk) disable iff (srst)
        cVal[0] == cVal[1]) else $error("pair outputs out of step");
    a_manual_dc: assert property (@(posedge ref_clk) disable iff (srst)
        (!ctrl_q[0][BIT_DC_EN] && complexAB) |-> (eDcI[0] == dcI_q[0])) else $error("manual dc not used");
    a_manual_skew: assert property (@(posedge ref_clk) disable iff (srst)
        !ctrl_q[0][BIT_SKEW_EN] |-> (eSkew[0] == skew_q[0])) else $error("manual skew not used");
    a_manual_gain: assert property (@(posedge ref_clk) disable iff (srst)
        !ctrl_q[0][BIT_GAIN_EN] |-> (eGain[0] == gain_q[0])) else $error("manual gain not used");
    a_skew_range: assert property (@(posedge ref_clk) disable iff (srst)
        (ctrl_q[0][BIT_SKEW_EN] && complexAB) |-> ($signed(eSkew[0]) <= TERM_LIMIT && $signed(eSkew[0]) >= -TERM_LIMIT))
        else $error("skew term out of range");
    a_gain_range: assert property (@(posedge ref_clk) disable iff (srst)
        (ctrl_q[0][BIT_GAIN_EN] && complexAB) |-> ($signed(eGain[0]) <= TERM_LIMIT && $signed(eGain[0]) >= -TERM_LIMIT))
        else $error("gain term out of range");
    a_out_valid_lat: assert property (@(posedge ref_clk) disable iff (srst)
        coreGo |=> outValid) else $error("sample lost");
    c_write_ctl: cover property (@(posedge ref_clk) wrLo && hitCtl);
    c_dc_auto: cover property (@(posedge ref_clk) ctrl_q[0][BIT_DC_EN] && coreGo);
    c_fifo_full: cover property (@(posedge ref_clk) !sampleReady);
    c_skew_auto: cover property (@(posedge ref_clk) ctrl_q[0][BIT_SKEW_EN] && complexAB && coreGo);
endmodule : iq_quadrature_correction

/* iq_adc_pair_model.sv */
// iq_adc_pair_model: the two adc pairs feeding complex words into the block.
// assumes the bench queues words with send(); ready is sampled at the rising edge.
`timescale 1ns/1ns
module iq_adc_pair_model (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    srst,
    // sample stream
    output logic                         sampleValid,
    input  wire logic                    sampleReady,
    output iq_corr_pkg::iq_sample_t      sampleAB,
    output iq_corr_pkg::iq_sample_t      sampleCD
);
    import iq_corr_pkg::*;
    iq_sample_t pendAB[$];
    iq_sample_t pendCD[$];

    task automatic send(input iq_sample_t ab, input iq_sample_t cd);
        pendAB.push_back(ab);
        pendCD.push_back(cd);
    endtask : send

    initial begin
        sampleValid = 1'b0;
        sampleAB    = '0;
        sampleCD    = '0;
    end

    // word held until ready seen high; idle data flips so stale values never match
    always @(posedge ref_clk) begin
        if (srst) begin
            sampleValid <= 1'b0;
        end else if (sampleValid !== 1'b1 || sampleReady === 1'b1) begin
            if (pendAB.size() != 0) begin
                sampleValid <= 1'b1;
                sampleAB    <= pendAB.pop_front();
                sampleCD    <= pendCD.pop_front();
            end else begin
                sampleValid <= 1'b0;
                sampleAB    <= ~sampleAB;
                sampleCD    <= ~sampleCD;
            end
        end
    end
endmodule : iq_adc_pair_model

/* iq_quadrature_correction_tb.sv */
// iq_quadrature_correction_tb: self-checking bench for registers and sample stream.
// assumes the adc pair model; expected words are queued and checked on outValid.
`timescale 1ns/1ns
module iq_quadrature_correction_tb;
    import iq_corr_pkg::*;
    typedef struct packed {logic [7:0] adr; logic [15:0] val; logic [31:0] eab; logic [31:0] ecd;} case_t;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    wb_req_t     req;
    logic [31:0] rdat;
    logic        ack;
    logic        err;
    logic        complexAB;
    logic        complexCD;
    logic        sampleValid;
    logic        sampleReady;
    logic        outValid;
    logic        outReady;
    logic        loose = 1'b0;
    iq_sample_t  sampleAB;
    iq_sample_t  sampleCD;
    iq_sample_t  outAB;
    iq_sample_t  outCD;
    iq_sample_t  lastAB;
    iq_sample_t  expAB[$];
    iq_sample_t  expCD[$];
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;
    integer      seed = 32'he000;
    logic [7:0]  ofs[5] = '{OFS_CONTROL, OFS_DC_I, OFS_DC_Q, OFS_GAIN, OFS_SKEW};
    logic [15:0] rstv[5] = '{RST_CONTROL, RST_DC, RST_DC, RST_GAIN, RST_SKEW};
    // input word is i=0x1000 q=0x0800 on both pairs
    case_t cases[7] = '{
        '{OFS_DC_I, 16'h0100, 32'h0f00_0800, 32'h1000_0800},
        '{OFS_DC_Q, 16'h0100, 32'h1000_0700, 32'h1000_0800},
        '{OFS_SKEW, 16'h1000, 32'h1080_0800, 32'h1000_0800},
        '{OFS_SKEW, 16'hf000, 32'h0f80_0800, 32'h1000_0800},
        '{OFS_GAIN, 16'h1000, 32'h1000_0880, 32'h1000_0800},
        '{OFS_GAIN, 16'hf000, 32'h1000_0780, 32'h1000_0800},
        '{OFS_DC_I | 8'h80, 16'h0200, 32'h1000_0800, 32'h0e00_0800}
    };

    always #2 ref_clk = ~ref_clk;

    iq_quadrature_correction dut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
        .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .complexAB(complexAB), .complexCD(complexCD),
        .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleAB(sampleAB), .sampleCD(sampleCD),
        .outValid(outValid), .outReady(outReady), .outAB(outAB), .outCD(outCD));
    iq_adc_pair_model adc (.ref_clk(ref_clk), .srst(srst), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .sampleAB(sampleAB), .sampleCD(sampleCD));

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // one classic cycle; read data taken at the ack edge only
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [15:0] wd, input logic [15:0] exp);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: adr, dat: {16'h0000, wd}};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        check({63'h0, ack}, 64'h1);
        check({63'h0, err}, 64'h0);
        if (!we)
            check({48'h0, rdat[15:0]}, {48'h0, exp});
        req <= '0;
    endtask : wb_xfer

    task automatic send(input iq_sample_t ab, input iq_sample_t cd, input iq_sample_t eab, input iq_sample_t ecd);
        expAB.push_back(eab);
        expCD.push_back(ecd);
        adc.send(ab, cd);
    endtask : send

    // waits for all queued words; rnd stalls the drain side at random
    task automatic drain(input string name, input bit rnd);
        int n;
        n = 0;
        while (expAB.size() != 0 && n < 4000) begin
            @(posedge ref_clk);
            outReady <= rnd ? 1'($random(seed)) : 1'b1;
            n++;
        end
        if (n >= 4000)
            check(64'h1, 64'h0);
        repeat (4) @(posedge ref_clk);
        outReady <= 1'b1;
        $display("test %s done", name);
    endtask : drain

    always @(posedge ref_clk) begin
        if (srst === 1'b0 && outValid === 1'b1) begin
            if (loose) begin
                lastAB <= outAB;
                check({32'h0, outCD}, 64'h1000_0800);
            end else if (expAB.size() == 0)
                check(64'h1, 64'h0);
            else
                check({outAB, outCD}, {expAB.pop_front(), expCD.pop_front()});
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        logic [31:0] r;
        logic [15:0] v;
        req = '0;
        complexAB = 1'b0;
        complexCD = 1'b0;
        outReady = 1'b1;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 5; k++) begin
                v = (k == 0) ? 16'hbab0 : 16'($random(seed));
                wb_xfer(1'b0, ofs[k] | (b ? 8'h80 : 8'h00), 16'h0000, rstv[k]);
                wb_xfer(1'b1, ofs[k] | (b ? 8'h80 : 8'h00), v, 16'h0000);
                wb_xfer(1'b0, ofs[k] | (b ? 8'h80 : 8'h00), 16'h0000, v);
                wb_xfer(1'b1, ofs[k] | (b ? 8'h80 : 8'h00), rstv[k], 16'h0000);
            end
        end
        wb_xfer(1'b1, 8'h18, 16'h1234, 16'h0000);
        wb_xfer(1'b0, 8'h18, 16'h0000, 16'h0000);
        $display("test registers done");
        complexAB <= 1'b1;
        complexCD <= 1'b1;
        wb_xfer(1'b0, OFS_STATUS, 16'h0000, 16'h0001);
        for (int c = 0; c < 7; c++) begin
            wb_xfer(1'b1, cases[c].adr, cases[c].val, 16'h0000);
            send(32'h1000_0800, 32'h1000_0800, cases[c].eab, cases[c].ecd);
            drain("manual correction", 1'b0);
            wb_xfer(1'b1, cases[c].adr, 16'h0000, 16'h0000);
        end
        complexAB <= 1'b0;
        complexCD <= 1'b0;
        wb_xfer(1'b1, OFS_DC_I, 16'h0100, 16'h0000);
        wb_xfer(1'b1, OFS_SKEW | 8'h80, 16'h1000, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            send(r, ~r, r, ~r);
        end
        drain("bypass", 1'b0);
        wb_xfer(1'b1, OFS_DC_I, 16'h0000, 16'h0000);
        wb_xfer(1'b1, OFS_SKEW | 8'h80, 16'h0000, 16'h0000);
        outReady <= 1'b0;
        for (int k = 0; k < FIFO_DEPTH + 1; k++) begin
            r = $random(seed);
            send(~r, r, ~r, r);
        end
        repeat (60) @(posedge ref_clk);
        check({63'h0, sampleReady}, 64'h0);
        check({63'h0, sampleValid}, 64'h1);
        drain("fifo fill and drain", 1'b1);
        // all three loops on for pair AB; the dc estimate must pull I below its raw level
        complexAB <= 1'b1;
        loose <= 1'b1;
        wb_xfer(1'b1, OFS_CONTROL, 16'h0007, 16'h0000);
        for (int k = 0; k < 8400; k++)
            adc.send(32'h1000_0800, 32'h1000_0800);
        repeat (8500) @(posedge ref_clk);
        check({63'h0, lastAB.i < 16'sh1000}, 64'h1);
        $display("test auto loops done");
        finish_test();
    end
endmodule : iq_quadrature_correction_tb
